// [core/prs_top.sv]
// Release status block: setting checks, LED codes, forced open, register slave
`timescale 1ns/100ps
module prs_top #(
   parameter int unsigned TICK_CYCLES = prs_pkg::TICK_CYC
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Avalon-MM slave
   input wire logic [prs_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   // Fault, supply and event pins
   input wire logic current_sensor_chain_err_i,
   input wire logic sensor_link_err_i,
   input wire logic plug_err_i,
   input wire logic test_btn_i,
   input wire logic aux_supply_i,
   input wire logic ext_battery_i,
   input wire logic [3:0] trip_evt_i,
   input wire logic [3:0] timing_alarm_i,
   input wire logic prealarm_i,
   // Setting switches
   input wire logic four_pole_i,
   input wire logic ext_neutral_i,
   input wire logic [1:0] neutral_threshold_ratio_i,
   input wire logic [3:0] overload_threshold_i,
   input wire logic [7:0] short_delay_thr_i,
   input wire logic [7:0] inst_thr_i,
   input wire logic [3:0] plug_rating_i,
   input wire logic [3:0] frame_rating_current_i,
   // Indicators and actuator
   output logic [3:0] led_red_o,
   output logic led_orange_o,
   output logic forced_open_command_o
);
   import prs_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // ------------------------------------------------------------
   // Input capture and timebase
   // ------------------------------------------------------------
   logic [16:0] ev;
   logic [29:0] sw;
   prs_tick_if tk ();

   prs_sync #(.W(17)) u_sync_ev (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
      .d_i({prealarm_i, timing_alarm_i, trip_evt_i, ext_neutral_i, four_pole_i,
            ext_battery_i, aux_supply_i, test_btn_i, plug_err_i, sensor_link_err_i,
            current_sensor_chain_err_i}),
      .q_o(ev));
   prs_sync #(.W(30)) u_sync_sw (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
      .d_i({frame_rating_current_i, plug_rating_i, overload_threshold_i,
            short_delay_thr_i, inst_thr_i, neutral_threshold_ratio_i}),
      .q_o(sw));
   prs_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .tb(tk));

   logic chain, link, plug, test, aux, batt, four, extn, pre;
   logic [3:0] trip, alarm, plug_r, frame;
   prs_set_t cur;
   assign {pre, alarm, trip, extn, four, batt, aux, test, plug, link, chain} = ev;
   assign {frame, plug_r} = sw[29:22];
   assign cur = prs_set_t'(sw[21:0]);

   // Flash patterns from the 24-step phase (6 s, common to 2, 3 and 0.5 s)
   logic fast, slow, dbl, alive;
   assign fast = !tk.phase[0];
   assign slow = !tk.phase[2];
   assign dbl = !tk.phase[1];
   assign alive = (tk.phase == 5'h00) || (tk.phase == 5'(PH_N / 2));

   // ------------------------------------------------------------
   // Setting checks
   // ------------------------------------------------------------
   // Neutral current in 1/16 of plug units against frame rating
   function automatic logic nr_fits(input logic [1:0] r);
      logic [11:0] base;
      logic [11:0] prod;
      base = 12'(plug_r) * 12'(cur.ovl);
      case (r)
         NR_50: prod = base;
         NR_100: prod = base << 1;
         NR_200: prod = base << 2;
         default: prod = 12'h000;
      endcase
      return prod <= {4'h0, frame, 4'h0};
   endfunction

   logic [1:0] eff_nr;
   logic clamp, incons, cfg_err, ext_sup, open_trig, fail_any;
   always_comb begin
      eff_nr = cur.nr;
      clamp = four && !nr_fits(cur.nr);
      if (clamp) begin
         if (cur.nr == NR_200 && nr_fits(NR_100)) begin
            eff_nr = NR_100;
         end else if (nr_fits(NR_50)) begin
            eff_nr = NR_50;
         end else begin
            eff_nr = NR_OFF;
         end
      end
   end
   assign incons = !(({4'h0, cur.ovl} < cur.sd) && (cur.sd < cur.inst));
   assign ext_sup = aux || batt;

   // ------------------------------------------------------------
   // Commit, last trip, forced open and LED drive
   // ------------------------------------------------------------
   prs_cm_t cm_reg, cm_next;
   prs_set_t stored_reg, stored_next;
   logic [3:0] cm_cnt_reg, cm_cnt_next, lt_cnt_reg, lt_cnt_next;
   logic [3:0] open_cnt_reg, open_cnt_next, alive_cnt_reg, alive_cnt_next;
   logic [3:0] lt_fn_reg, lt_fn_next, trip_prev_reg;
   logic [1:0] cause_reg, cause_next;
   logic lt_act_reg, lt_act_next, generic_reg, generic_next;
   logic alive_rdy_reg, alive_rdy_next, fo_next, orange_next, red_act, commit_ok;
   logic [3:0] red_next;
   logic ctrl_reg;

   // Unpowered neutral on a bare three-pole frame counts as misconfiguration
   assign cfg_err = (cur != stored_reg) || (!four && !extn && cur.nr != NR_OFF);
   assign commit_ok = cfg_err && !chain && !link && !plug && !incons
                      && batt && !aux;
   assign open_trig = ctrl_reg && (link || plug
                      || (!four && !extn && cur.nr != NR_OFF));
   assign fail_any = chain || link || plug || (|cause_reg);

   always_comb begin
      cm_next = cm_reg;
      cm_cnt_next = cm_cnt_reg;
      stored_next = stored_reg;
      lt_act_next = lt_act_reg;
      lt_fn_next = lt_fn_reg;
      lt_cnt_next = lt_cnt_reg;
      open_cnt_next = open_cnt_reg;
      fo_next = forced_open_command_o;
      generic_next = generic_reg;
      cause_next = cause_reg;
      alive_cnt_next = alive_cnt_reg;
      alive_rdy_next = alive_rdy_reg;
      if (alive_cnt_reg == ALIVE_TK + 4'h1) begin
         alive_rdy_next = 1'b1;
      end else if (tk.tick) begin
         alive_cnt_next = alive_cnt_reg + 4'h1;
      end
      case (cm_reg)
         PRS_CM_IDLE: begin
            cm_cnt_next = 4'h0;
            if (test && commit_ok) begin
               cm_next = PRS_CM_HOLD;
            end
         end
         PRS_CM_HOLD: begin
            if (!test || !commit_ok) begin
               cm_next = PRS_CM_IDLE;
            end else if (cm_cnt_reg == COMMIT_TK + 4'h1) begin
               stored_next = cur;
               cm_next = PRS_CM_CONF;
               cm_cnt_next = 4'h0;
            end else if (tk.tick) begin
               cm_cnt_next = cm_cnt_reg + 4'h1;
            end
         end
         PRS_CM_CONF: begin
            if (cm_cnt_reg == CONFIRM_TK) begin
               cm_next = PRS_CM_IDLE;
            end else if (tk.tick) begin
               cm_cnt_next = cm_cnt_reg + 4'h1;
            end
         end
         default: cm_next = PRS_CM_IDLE;
      endcase
      if (|(trip & ~trip_prev_reg)) begin
         lt_act_next = 1'b1;
         lt_fn_next = trip & ~trip_prev_reg;
         lt_cnt_next = 4'h0;
      end else if (lt_act_reg && !ext_sup) begin
         if (lt_cnt_reg == LAST_TRIP_TK) begin
            lt_act_next = 1'b0;
         end else if (tk.tick) begin
            lt_cnt_next = lt_cnt_reg + 4'h1;
         end
      end
      if (!open_trig) begin
         open_cnt_next = 4'h0;
         fo_next = 1'b0;
      end else if (open_cnt_reg == OPEN_TK + 4'h1) begin
         fo_next = 1'b1;
         if (!forced_open_command_o && ext_sup) begin
            cause_next = cause_reg | {link, plug};
         end else if (!forced_open_command_o) begin
            generic_next = 1'b1;
         end
      end else if (tk.tick) begin
         open_cnt_next = open_cnt_reg + 4'h1;
      end
      // Red group: faults outrank the operator displays
      red_act = 1'b1;
      if (chain) begin
         red_next = {4{fast}};
      end else if (link || cause_reg[1]) begin
         red_next = {4{slow}};
      end else if (plug || cause_reg[0]) begin
         red_next = {4{dbl}};
      end else if (cm_reg == PRS_CM_CONF) begin
         red_next = {4{fast}};
      end else if (test && generic_reg) begin
         red_next = 4'(1 << LED_I);
      end else if (test) begin
         red_next = 4'hf;
      end else if (lt_act_reg) begin
         red_next = lt_fn_reg;
      end else if (|alarm) begin
         red_next = alarm & {4{fast}};
      end else begin
         red_next = 4'h0;
         red_act = 1'b0;
      end
      if ((test && generic_reg && !fail_any && cm_reg != PRS_CM_CONF) || pre) begin
         orange_next = 1'b1;
      end else if (cfg_err) begin
         orange_next = fast;
      end else if (incons) begin
         orange_next = dbl;
      end else begin
         orange_next = !red_act && alive_rdy_reg && alive;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cm_reg <= PRS_CM_IDLE;
         cm_cnt_reg <= 4'h0;
         stored_reg <= SET_RST;
         lt_act_reg <= 1'b0;
         lt_fn_reg <= 4'h0;
         lt_cnt_reg <= 4'h0;
         trip_prev_reg <= 4'h0;
         open_cnt_reg <= 4'h0;
         forced_open_command_o <= 1'b0;
         generic_reg <= 1'b0;
         cause_reg <= 2'h0;
         alive_cnt_reg <= 4'h0;
         alive_rdy_reg <= 1'b0;
         led_red_o <= 4'h0;
         led_orange_o <= 1'b0;
      end else if (ce_i) begin
         cm_reg <= cm_next;
         cm_cnt_reg <= cm_cnt_next;
         stored_reg <= stored_next;
         lt_act_reg <= lt_act_next;
         lt_fn_reg <= lt_fn_next;
         lt_cnt_reg <= lt_cnt_next;
         trip_prev_reg <= trip;
         open_cnt_reg <= open_cnt_next;
         forced_open_command_o <= fo_next;
         generic_reg <= generic_next;
         cause_reg <= cause_next;
         alive_cnt_reg <= alive_cnt_next;
         alive_rdy_reg <= alive_rdy_next;
         led_red_o <= red_next;
         led_orange_o <= orange_next;
      end
   end

   // ------------------------------------------------------------
   // Register slave and interrupt
   // ------------------------------------------------------------
   logic [ST_W-1:0] sts_reg, sts_next, en_reg, en_next, cond, prev_reg, clr;
   logic [31:0] rd_next, bmask, state_v;
   logic wait_next, ctrl_next, irq_next, acc;
   logic [4:0] wadr;

   always_comb begin
      cond = '0;
      cond[ST_CHAIN] = chain;
      cond[ST_LINK] = link;
      cond[ST_PLUG] = plug;
      cond[ST_CFG] = cfg_err;
      cond[ST_INCONS] = incons;
      cond[ST_CLAMP] = clamp;
      cond[ST_OPEN] = forced_open_command_o;
      cond[ST_TRIP] = |trip;
      cond[ST_COMMIT] = (cm_reg == PRS_CM_CONF);
      state_v = 32'h0;
      state_v[SF_EFF +: 2] = eff_nr;
      state_v[SF_STO +: 2] = stored_reg.nr;
      state_v[SF_FSM +: 2] = cm_reg;
      state_v[SF_CAUSE +: 2] = cause_reg;
      state_v[SF_GEN] = generic_reg;
      bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
               {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      wadr = {avs_address_i[ADDR_W-1:2], 2'h0};
      // Write is taken on the second cycle, when waitrequest is already low; read data is captured on the first
      acc = avs_write_i && !avs_waitrequest_o;
      wait_next = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      rd_next = avs_readdata_o;
      if (avs_read_i && avs_waitrequest_o) begin
         case (wadr)
            A_STATUS: rd_next = 32'(sts_reg);
            A_EN: rd_next = 32'(en_reg);
            A_CTRL: rd_next = 32'(ctrl_reg);
            A_STATE: rd_next = state_v;
            default: rd_next = 32'h0;
         endcase
      end
      clr = (acc && wadr == A_CLR) ? ST_W'(avs_writedata_i & bmask) : '0;
      en_next = en_reg;
      if (acc && wadr == A_EN) begin
         en_next = ST_W'((32'(en_reg) & ~bmask) | (avs_writedata_i & bmask));
      end
      ctrl_next = ctrl_reg;
      if (acc && wadr == A_CTRL && avs_byteenable_i[0]) begin
         ctrl_next = avs_writedata_i[CT_OPEN_EN];
      end
      // New edge beats a clear in the same cycle
      sts_next = (sts_reg & ~clr) | (cond & ~prev_reg);
      irq_next = |(sts_reg & en_reg);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
         sts_reg <= '0;
         en_reg <= EN_RST;
         ctrl_reg <= CTRL_RST;
         prev_reg <= '0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         avs_waitrequest_o <= wait_next;
         avs_readdata_o <= rd_next;
         sts_reg <= sts_next;
         en_reg <= en_next;
         ctrl_reg <= ctrl_next;
         prev_reg <= cond;
         irq_o <= irq_next;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_clamp_fit: assert property (
      four |-> (eff_nr == NR_OFF || nr_fits(eff_nr)) && eff_nr <= cur.nr)
      else $error("neutral ratio not clamped");
   a_three_pole: assert property (!four |-> eff_nr == cur.nr)
      else $error("three-pole neutral altered");
   a_commit_store: assert property (
      cm_reg == PRS_CM_HOLD ##1 cm_reg == PRS_CM_CONF |-> stored_reg == $past(cur))
      else $error("commit did not store settings");
   a_cfg_flash: assert property (
      ce_i && cfg_err && !pre && !test |=> led_orange_o == $past(fast))
      else $error("configuration flash wrong");
   a_alive_wait: assert property (
      $rose(alive_rdy_reg) |-> $past(alive_cnt_reg) == ALIVE_TK + 4'h1)
      else $error("alive pulse started early");
   a_chain_flash: assert property (
      ce_i && chain |=> led_red_o == {4{$past(fast)}})
      else $error("sensor chain pattern wrong");
   a_link_slow: assert property (
      ce_i && !chain && link |=> led_red_o == {4{$past(slow)}})
      else $error("sensor link pattern wrong");
   a_test_steady: assert property (
      ce_i && test && !fail_any && !generic_reg && cm_reg != PRS_CM_CONF
      |=> led_red_o == 4'hf)
      else $error("test display not steady");
   a_open_delay: assert property (
      $rose(forced_open_command_o) |-> $past(open_trig)
      && $past(open_cnt_reg) == OPEN_TK + 4'h1)
      else $error("forced open timing wrong");
   a_hw_show: assert property (
      ce_i && test && generic_reg && !fail_any && cm_reg != PRS_CM_CONF
      |=> led_red_o == 4'(1 << LED_I) && led_orange_o)
      else $error("generic trip display wrong");
   a_bus_answer: assert property (
      ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer late");
endmodule

// [core/prs_pkg.sv]
// Constants, register map and types of the protection release status block
package prs_pkg;
   // ------------------------------------------------------------
   // Timebase
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned TICK_MS = 250;
   localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned PH_N = 24;
   localparam int unsigned ALIVE_MS = 3000;
   localparam int unsigned LAST_TRIP_MS = 2000;
   localparam int unsigned OPEN_MS = 1000;
   localparam int unsigned COMMIT_MS = 3000;
   localparam int unsigned CONFIRM_MS = 2000;
   localparam logic [3:0] ALIVE_TK = 4'((ALIVE_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [3:0] LAST_TRIP_TK = 4'((LAST_TRIP_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [3:0] OPEN_TK = 4'((OPEN_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [3:0] COMMIT_TK = 4'((COMMIT_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [3:0] CONFIRM_TK = 4'((CONFIRM_MS + TICK_MS - 1) / TICK_MS);
   // ------------------------------------------------------------
   // Settings
   // ------------------------------------------------------------
   localparam logic [1:0] NR_OFF = 2'h0;
   localparam logic [1:0] NR_50 = 2'h1;
   localparam logic [1:0] NR_100 = 2'h2;
   localparam logic [1:0] NR_200 = 2'h3;
   typedef struct packed {
      logic [3:0] ovl;
      logic [7:0] sd;
      logic [7:0] inst;
      logic [1:0] nr;
   } prs_set_t;
   localparam prs_set_t SET_RST = '{ovl: 4'h0, sd: 8'h00, inst: 8'h00, nr: NR_50};
   localparam int unsigned LED_I = 2;
   typedef enum logic [1:0] {
      PRS_CM_IDLE = 2'h0,
      PRS_CM_HOLD = 2'h1,
      PRS_CM_CONF = 2'h3
   } prs_cm_t;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 5;
   localparam logic [4:0] A_STATUS = 5'h00;
   localparam logic [4:0] A_CLR = 5'h04;
   localparam logic [4:0] A_EN = 5'h08;
   localparam logic [4:0] A_CTRL = 5'h0c;
   localparam logic [4:0] A_STATE = 5'h10;
   localparam int unsigned ST_CHAIN = 0;
   localparam int unsigned ST_LINK = 1;
   localparam int unsigned ST_PLUG = 2;
   localparam int unsigned ST_CFG = 3;
   localparam int unsigned ST_INCONS = 4;
   localparam int unsigned ST_CLAMP = 5;
   localparam int unsigned ST_OPEN = 6;
   localparam int unsigned ST_TRIP = 7;
   localparam int unsigned ST_COMMIT = 8;
   localparam int unsigned ST_W = 9;
   localparam logic [8:0] EN_RST = 9'h000;
   localparam int unsigned CT_OPEN_EN = 0;
   localparam logic CTRL_RST = 1'b1;
   localparam int unsigned SF_EFF = 0;
   localparam int unsigned SF_STO = 2;
   localparam int unsigned SF_FSM = 4;
   localparam int unsigned SF_CAUSE = 6;
   localparam int unsigned SF_GEN = 8;
endpackage

// [core/prs_tick_if.sv]
// Slow timebase carrier: tick pulse and flash phase
`timescale 1ns/100ps
interface prs_tick_if;
   logic tick;
   logic [4:0] phase;
   modport src (output tick, output phase);
   modport dst (input tick, input phase);
endinterface

// [core/prs_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module prs_sync #(
   parameter int unsigned W = 1
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_next;

   // A bit only moves once stages two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_o[i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_o <= '0;
      end else if (ce_i) begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_o <= q_next;
      end
   end
endmodule

// [core/prs_timebase.sv]
// Slow timebase: quarter-second tick and 24-step flash phase
`timescale 1ns/100ps
module prs_timebase #(
   parameter int unsigned TICK_CYCLES = prs_pkg::TICK_CYC
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Timebase out
   prs_tick_if.src tb
);
   import prs_pkg::*;
   logic [22:0] cnt_reg;
   logic [22:0] cnt_next;
   logic tick_next;
   logic [4:0] ph_next;

   always_comb begin
      cnt_next = cnt_reg + 23'h1;
      tick_next = 1'b0;
      ph_next = tb.phase;
      if (cnt_reg == 23'(TICK_CYCLES - 1)) begin
         cnt_next = 23'h0;
         tick_next = 1'b1;
         ph_next = (tb.phase == 5'(PH_N - 1)) ? 5'h00 : tb.phase + 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cnt_reg <= 23'h0;
         tb.tick <= 1'b0;
         tb.phase <= 5'h00;
      end else if (ce_i) begin
         cnt_reg <= cnt_next;
         tb.tick <= tick_next;
         tb.phase <= ph_next;
      end
   end
endmodule

// [tb/prs_partner.sv]
// Far-side model: operator test button, supplies and breaker actuator
`timescale 1ns/100ps
module prs_partner (
   // Clock and bench commands
   input wire logic clk_i,
   input wire logic press_i,
   input wire logic batt_only_i,
   input wire logic forced_open_command_i,
   // Pins toward the release
   output logic test_btn_o,
   output logic aux_supply_o,
   output logic ext_battery_o,
   output logic opened_o
);
   initial begin
      test_btn_o = 1'b0;
      aux_supply_o = 1'b0;
      ext_battery_o = 1'b0;
      opened_o = 1'b0;
   end
   always @(posedge clk_i) begin
      test_btn_o <= press_i;
      ext_battery_o <= batt_only_i;
      aux_supply_o <= ~batt_only_i;
      // Breaker stays open once commanded
      if (forced_open_command_i) begin
         opened_o <= 1'b1;
      end
   end
endmodule

// [tb/prs_top_tb.sv]
// Self-checking bench for the release status block
`timescale 1ns/100ps
module prs_top_tb;
   import prs_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wd = 32'h0;
   logic chain = 1'b0;
   logic link = 1'b0;
   logic press = 1'b0;
   logic four = 1'b1;
   logic extn = 1'b0;
   logic [1:0] nr = NR_50;
   logic [7:0] sd = 8'h10;
   logic [3:0] plug = 4'h4;
   logic ce = 1'b1;
   logic batt_only = 1'b1;
   logic pe = 1'b0;
   logic [3:0] trip = 4'h0;
   logic [3:0] alarm = 4'h0;
   logic pre = 1'b0;
   logic [31:0] q, rdat;
   logic [3:0] red;
   logic [4:0] seen_on, seen_off;
   logic wt, irq, tbtn, aux, batt, opened, fo, org;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #25 clk_i = ~clk_i;
   prs_partner u_prs_partner (.clk_i(clk_i), .press_i(press), .batt_only_i(batt_only),
      .forced_open_command_i(fo), .test_btn_o(tbtn), .aux_supply_o(aux),
      .ext_battery_o(batt), .opened_o(opened));
   prs_top #(.TICK_CYCLES(20)) u_prs_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(irq),
      .current_sensor_chain_err_i(chain), .sensor_link_err_i(link), .plug_err_i(pe),
      .test_btn_i(tbtn), .aux_supply_i(aux), .ext_battery_i(batt), .trip_evt_i(trip),
      .timing_alarm_i(alarm), .prealarm_i(pre), .four_pole_i(four), .ext_neutral_i(extn),
      .neutral_threshold_ratio_i(nr), .overload_threshold_i(4'h8), .short_delay_thr_i(sd),
      .inst_thr_i(8'h20), .plug_rating_i(plug), .frame_rating_current_i(4'h8),
      .led_red_o(red), .led_orange_o(org), .forced_open_command_o(fo));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_i);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk_i);
      end while (wt !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Lit-ever and lit-always masks of {orange, red} over n cycles
   task automatic look(input int n);
      seen_on = 5'h00;
      seen_off = 5'h1f;
      repeat (n) begin
         @(posedge clk_i);
         seen_on = seen_on | {org, red};
         seen_off = seen_off & {org, red};
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      tk(3);
      rst_b_i <= 1'b1;
      tk(10);
      acc(1'b0, A_CTRL, 32'h0);
      chk(q, 32'h1);
      acc(1'b0, 5'h14, 32'h0);
      chk(q, 32'h0);
      acc(1'b0, A_STATE, 32'h0);
      chk(q & 32'hc, 32'h4);
      acc(1'b0, A_STATUS, 32'h0);
      chk(q & 32'h8, 32'h8);
      $display("test reset done");
      acc(1'b1, A_EN, 32'h100);
      press <= 1'b1;
      tk(300);
      press <= 1'b0;
      tk(10);
      acc(1'b0, A_STATUS, 32'h0);
      chk(q & 32'h100, 32'h100);
      chk(32'(irq), 32'h1);
      acc(1'b1, A_CLR, 32'h100);
      tk(3);
      chk(32'(irq), 32'h0);
      tk(200);
      press <= 1'b1;
      tk(10);
      chk(32'(red), 32'hf);
      press <= 1'b0;
      $display("test commit done");
      acc(1'b1, A_CLR, 32'h3f);
      nr <= NR_200;
      plug <= 4'h8;
      tk(10);
      acc(1'b0, A_STATE, 32'h0);
      chk(q & 32'h3, 32'(NR_100));
      acc(1'b0, A_STATUS, 32'h0);
      chk(q & 32'h30, 32'h20);
      four <= 1'b0;
      extn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         nr <= 2'(i);
         tk(10);
         acc(1'b0, A_STATE, 32'h0);
         chk(q & 32'h3, 32'(i));
      end
      acc(1'b1, A_CLR, 32'h30);
      sd <= 8'h08;
      tk(10);
      acc(1'b0, A_STATUS, 32'h0);
      chk(q & 32'h30, 32'h10);
      sd <= 8'h10;
      $display("test settings done");
      link <= 1'b1;
      tk(80);
      chk(32'(fo), 32'h0);
      chk(32'(opened), 32'h0);
      tk(60);
      chk(32'(fo), 32'h1);
      chk(32'(opened), 32'h1);
      acc(1'b0, A_STATE, 32'h0);
      chk(q & 32'hc0, 32'h80);
      link <= 1'b0;
      tk(10);
      chk(32'(fo), 32'h0);
      $display("test forced open done");
      // Second reset drops latched causes and stored settings
      rst_b_i <= 1'b0;
      tk(3);
      rst_b_i <= 1'b1;
      tk(10);
      acc(1'b0, A_STATE, 32'h0);
      chk(q & 32'h1c0, 32'h0);
      look(45);
      chk(32'({seen_on, seen_off}), 32'h200);
      // Aux supply present: the held button must not commit
      batt_only <= 1'b0;
      press <= 1'b1;
      tk(300);
      acc(1'b0, A_STATE, 32'h0);
      chk(q & 32'h30, 32'h0);
      batt_only <= 1'b1;
      tk(300);
      press <= 1'b0;
      tk(200);
      look(250);
      chk(32'({seen_on, seen_off}), 32'h200);
      alarm <= 4'h2;
      pre <= 1'b1;
      tk(10);
      look(45);
      chk(32'({seen_on, seen_off}), 32'h250);
      alarm <= 4'h0;
      pre <= 1'b0;
      trip <= 4'h4;
      tk(10);
      look(45);
      chk(32'({seen_on[3:0], seen_off[3:0]}), 32'h44);
      pe <= 1'b1;
      tk(10);
      look(110);
      chk(32'({seen_on[3:0], seen_off[3:0]}), 32'hf0);
      chk(32'(fo), 32'h1);
      acc(1'b0, A_STATE, 32'h0);
      chk(q & 32'hc0, 32'h40);
      $display("test display done");
      chain <= 1'b1;
      tk(10);
      look(60);
      chk(32'({seen_on[3:0], seen_off[3:0]}), 32'hf0);
      ce <= 1'b0;
      look(50);
      chk(32'(seen_on ^ seen_off), 32'h0);
      ce <= 1'b1;
      $display("test sensor chain done");
      end_sim();
   end
endmodule
